// *** adcz_slot_ctrl.sv ***
// AHB-Lite register block with zero-crossing modes and sample input routing.
//
// Operation
// - Mode register holds eight 2-bit fields; slot 15 top, slot 8 bottom.
// - Mode 00 disables detection; 01 detects positive-to-negative changes only.
// - Mode 10 detects negative-to-positive changes; 11 detects either direction.
// - Selector register holds four nibbles; slot 3 highest, slot 0 lowest.
// - Single-ended codes 0-7 pick group A inputs, 8-15 group B.
// - Differential ignores the low bit: even input positive, next odd negative.
// - A set disable bit stops its slot and every later slot.
// - Mode register sits at word index 3, selector register at index 4.
// - Reset clears all mode fields; selectors reset to codes 0,1,2,3.
`timescale 1ns/1ns
`default_nettype none
`include "adcz_map.svh"
module adcz_slot_ctrl
  import adcz_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire adcz_result_s result,
  output logic [15:0] zxModes,
  output adcz_route_s [3:0] slotRoute,
  output logic [15:0] slotEnable,
  output logic [7:0] crossFlags
);
  // ****************************************************************
  // Bus slave state.
  // ****************************************************************
  adcz_bus_e bus_q;
  logic wr_q;
  logic mapped_q;
  logic [5:0] idx_q;
  logic accept;
  logic wrStrobe;
  logic [15:0] selQ;
  logic [15:0] sdisQ;
  logic diffQ;
  logic [7:0] crossEvt;
  logic [31:0] readWord;

  // Only whole-word transfers are expected, so hsize is not decoded.
  assign accept = hsel && htrans[`ADCZ_HTRANS_ACT] && hready;
  assign wrStrobe = (bus_q == BUS_WAIT) && wr_q && mapped_q;

  // Every transfer takes one wait state so that read data leave a register.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bus_q <= BUS_IDLE;
      hreadyout <= 1'h1;
      wr_q <= 1'h0;
      mapped_q <= 1'h0;
      idx_q <= 6'h00;
    end else begin
      case (bus_q)
        BUS_IDLE: begin
          if (accept) begin
            bus_q <= BUS_WAIT;
            hreadyout <= 1'h0;
            wr_q <= hwrite;
            idx_q <= haddr[`ADCZ_IDX_MSB:`ADCZ_IDX_LSB];
            mapped_q <= (haddr[31:`ADCZ_UPPER_LSB] == 24'h000000);
          end
        end
        BUS_WAIT: begin
          bus_q <= BUS_IDLE;
          hreadyout <= 1'h1;
        end
        default: begin
          bus_q <= BUS_IDLE;
          hreadyout <= 1'h1;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      hresp <= 1'h0;
    end else begin
      hresp <= 1'h0;
    end
  end

  // ****************************************************************
  // Read decode.
  // ****************************************************************
  function automatic logic [31:0] regRead(input logic [5:0] idx, input logic [15:0] zx,
                                          input logic [15:0] sel, input logic [15:0] sdis,
                                          input logic [7:0] flags, input logic diff);
    case (idx)
      `ADCZ_IDX_ZXMODE: regRead = {16'h0000, zx};
      `ADCZ_IDX_INSEL: regRead = {16'h0000, sel};
      `ADCZ_IDX_SDIS: regRead = {16'h0000, sdis};
      `ADCZ_IDX_XFLAG: regRead = {24'h000000, flags};
      `ADCZ_IDX_CTRL: regRead = {31'h00000000, diff};
      default: regRead = 32'h00000000;
    endcase
  endfunction

  assign readWord = mapped_q ? regRead(idx_q, zxModes, selQ, sdisQ, crossFlags, diffQ)
                             : 32'h00000000;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      hrdata <= 32'h00000000;
    end else if (bus_q == BUS_WAIT && !wr_q) begin
      hrdata <= readWord;
    end
  end

  // ****************************************************************
  // Software-written registers.
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      zxModes <= `ADCZ_RST_ZXMODE;
    end else if (wrStrobe && idx_q == `ADCZ_IDX_ZXMODE) begin
      zxModes <= hwdata[`ADCZ_REG_W-1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      selQ <= `ADCZ_RST_INSEL;
    end else if (wrStrobe && idx_q == `ADCZ_IDX_INSEL) begin
      selQ <= hwdata[`ADCZ_REG_W-1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sdisQ <= `ADCZ_RST_SDIS;
    end else if (wrStrobe && idx_q == `ADCZ_IDX_SDIS) begin
      sdisQ <= hwdata[`ADCZ_REG_W-1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      diffQ <= `ADCZ_RST_CTRL;
    end else if (wrStrobe && idx_q == `ADCZ_IDX_CTRL) begin
      diffQ <= hwdata[`ADCZ_CTRL_DIFF];
    end
  end

  // ****************************************************************
  // Crossing detection and sticky flags.
  // ****************************************************************
  adcz_cross_det u_cross (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .result(result),
    .modes(zxModes),
    .crossEvt(crossEvt)
  );

  // A new crossing in the cycle of a write-one-to-clear keeps its flag set.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      crossFlags <= `ADCZ_RST_XFLAG;
    end else if (wrStrobe && idx_q == `ADCZ_IDX_XFLAG) begin
      crossFlags <= (crossFlags & ~hwdata[7:0]) | crossEvt;
    end else begin
      crossFlags <= crossFlags | crossEvt;
    end
  end

  // ****************************************************************
  // Input routing for sample slots 0 to 3.
  // ****************************************************************
  function automatic adcz_route_s pickRoute(input logic [3:0] code, input logic diff);
    adcz_route_s r;
    r.diff = diff;
    if (diff) begin
      r.posInput = {code[3:1], 1'h0};
      r.negInput = {code[3:1], 1'h1};
    end else begin
      // Bit 3 picks group B, bits 2 to 0 the input within the group.
      r.posInput = code;
      r.negInput = code;
    end
    pickRoute = r;
  endfunction

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      slotRoute <= '0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        slotRoute[i] <= pickRoute(selQ[i*`ADCZ_PICK_W +: `ADCZ_PICK_W], diffQ);
      end
    end
  end

  // ****************************************************************
  // Scan-list truncation.
  // ****************************************************************
  function automatic logic [15:0] tailEnable(input logic [15:0] dis);
    logic seen;
    seen = 1'h0;
    for (int i = 0; i < 16; i++) begin
      seen = seen | dis[i];
      tailEnable[i] = !seen;
    end
  endfunction

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      slotEnable <= 16'hFFFF;
    end else begin
      slotEnable <= tailEnable(sdisQ);
    end
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************
  a_mode_field_map: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wrStrobe && idx_q == `ADCZ_IDX_ZXMODE)
    |=> zxModes[15:14] == $past(hwdata[15:14]) && zxModes[1:0] == $past(hwdata[1:0]))
    else $error("mode field not stored at its bit pair");
  a_route_nibbles: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $stable(selQ) |=> slotRoute[3].posInput[3:1] == $past(selQ[15:13])
                   && slotRoute[2].posInput[3:1] == $past(selQ[11:9]))
    else $error("selector nibble routed to wrong slot");
  a_single_pick: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!diffQ && $stable(selQ)) |=> slotRoute[0].posInput == $past(selQ[3:0])
      && slotRoute[1].posInput == $past(selQ[7:4])
      && !slotRoute[0].diff)
    else $error("single-ended input pick mismatch");
  a_diff_pair: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (diffQ && $stable(diffQ)) |=> slotRoute[1].posInput[0] == 1'h0
      && slotRoute[1].negInput == {slotRoute[1].posInput[3:1], 1'h1})
    else $error("differential pair mismatch");
  a_disable_tail: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sdisQ[2] |=> slotEnable[15:2] == 14'h0000
      && slotEnable[1:0] == {~|$past(sdisQ[1:0]), ~$past(sdisQ[0])})
    else $error("later slots not stopped");
  a_read_offset: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (accept && !hwrite && haddr == 32'h0000000C)
    |-> ##2 (hreadyout && hrdata == {16'h0000, zxModes}))
    else $error("mode register not read at index 3");
  a_reset_values: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(rst_n) |-> zxModes == 16'h0000 && selQ == 16'h3210)
    else $error("wrong reset value");
  a_flag_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (crossEvt != 8'h00) |=> (crossFlags & $past(crossEvt)) == $past(crossEvt))
    else $error("crossing flag lost");
endmodule
`default_nettype wire

// *** adcz_map.svh ***
// Register indices, reset values, field positions and codes of the converter slot control block.
`ifndef ADCZ_MAP_SVH
`define ADCZ_MAP_SVH
// ****************************************************************
// Register word indices; byte address is four times the index.
// ****************************************************************
`define ADCZ_IDX_ZXMODE 6'h03
`define ADCZ_IDX_INSEL 6'h04
`define ADCZ_IDX_SDIS 6'h06
`define ADCZ_IDX_XFLAG 6'h07
`define ADCZ_IDX_CTRL 6'h08
`define ADCZ_IDX_LSB 2
`define ADCZ_IDX_MSB 7
`define ADCZ_UPPER_LSB 8
// ****************************************************************
// Reset values.
// ****************************************************************
`define ADCZ_RST_ZXMODE 16'h0000
`define ADCZ_RST_INSEL 16'h3210
`define ADCZ_RST_SDIS 16'h0000
`define ADCZ_RST_CTRL 1'h0
`define ADCZ_RST_XFLAG 8'h00
// ****************************************************************
// Field layout and codes.
// ****************************************************************
`define ADCZ_REG_W 16
`define ADCZ_RES_W 16
`define ADCZ_PICK_W 4
`define ADCZ_ZC_W 2
`define ADCZ_ZC_OFF 2'h0
`define ADCZ_ZC_FALL 2'h1
`define ADCZ_ZC_RISE 2'h2
`define ADCZ_ZC_ANY 2'h3
`define ADCZ_CTRL_DIFF 0
`define ADCZ_HTRANS_ACT 1
`endif

// *** adcz_pkg.sv ***
// Types shared by the converter slot control block.
package adcz_pkg;
  typedef struct packed {
    logic valid;
    logic [3:0] slot;
    logic [15:0] data;
  } adcz_result_s;
  typedef struct packed {
    logic diff;
    logic [3:0] posInput;
    logic [3:0] negInput;
  } adcz_route_s;
  typedef enum logic {BUS_IDLE, BUS_WAIT} adcz_bus_e;
endpackage

// *** adcz_cross_det.sv ***
// Sign-change detector for result slots 8 to 15.
`timescale 1ns/1ns
`default_nettype none
`include "adcz_map.svh"
module adcz_cross_det
  import adcz_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire adcz_result_s result,
  input wire logic [15:0] modes,
  output logic [7:0] crossEvt
);
  // ****************************************************************
  // Previous sign per slot.
  // ****************************************************************
  logic [7:0] prevSign_q;
  logic [7:0] prevSeen_q;
  logic upperHit;
  logic [2:0] lane;
  logic nowSign;
  logic [1:0] laneMode;

  function automatic logic signMatch(input logic [1:0] mode, input logic was,
                                     input logic now);
    case (mode)
      `ADCZ_ZC_FALL: signMatch = !was && now;
      `ADCZ_ZC_RISE: signMatch = was && !now;
      `ADCZ_ZC_ANY: signMatch = was != now;
      default: signMatch = 1'h0;
    endcase
  endfunction

  assign upperHit = result.valid && result.slot[3];
  assign lane = result.slot[2:0];
  assign nowSign = result.data[`ADCZ_RES_W-1];
  assign laneMode = modes[lane*`ADCZ_ZC_W +: `ADCZ_ZC_W];

  // The first result after reset has no predecessor, so it only seeds the sign.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      prevSign_q <= 8'h00;
      prevSeen_q <= 8'h00;
    end else if (upperHit) begin
      prevSign_q[lane] <= nowSign;
      prevSeen_q[lane] <= 1'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      crossEvt <= 8'h00;
    end else begin
      crossEvt <= 8'h00;
      if (upperHit && prevSeen_q[lane]) begin
        crossEvt[lane] <= signMatch(laneMode, prevSign_q[lane], nowSign);
      end
    end
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************
  a_off_silent: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (upperHit && laneMode == `ADCZ_ZC_OFF) |=> crossEvt == 8'h00)
    else $error("crossing flagged on a disabled slot");
  a_fall_detect: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (upperHit && prevSeen_q[lane] && laneMode == `ADCZ_ZC_FALL && !prevSign_q[lane])
    |=> crossEvt[$past(lane)] == $past(nowSign))
    else $error("falling crossing mismatch");
  a_rise_detect: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (upperHit && prevSeen_q[lane] && laneMode == `ADCZ_ZC_RISE && prevSign_q[lane])
    |=> crossEvt[$past(lane)] == !$past(nowSign))
    else $error("rising crossing mismatch");
  a_any_detect: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (upperHit && prevSeen_q[lane] && laneMode == `ADCZ_ZC_ANY)
    |=> crossEvt[$past(lane)] == ($past(nowSign) != $past(prevSign_q[lane])))
    else $error("any-direction crossing mismatch");
endmodule
`default_nettype wire

// *** adcz_seq_model.sv ***
// Conversion sequencer stand-in that presents slot results to the control block.
`timescale 1ns/1ns
`default_nettype none
module adcz_seq_model
  import adcz_pkg::*;
(
  input wire logic sys_clk,
  output adcz_result_s result
);
  initial begin
    result = '0;
  end
  // Outside a result the bus shows the inverse of the last one, so a stale sample never matches.
  task automatic send(input logic [3:0] s, input logic [15:0] d, input int gap);
    repeat (gap) @(posedge sys_clk);
    @(posedge sys_clk);
    result <= '{valid: 1'b1, slot: s, data: d};
    @(posedge sys_clk);
    result <= '{valid: 1'b0, slot: ~s, data: ~d};
  endtask
endmodule
`default_nettype wire

// *** adcz_slot_ctrl_tb.sv ***
// Self-checking bench for the converter slot control block.
`timescale 1ns/1ns
`default_nettype none
module adcz_slot_ctrl_tb
  import adcz_pkg::*;
;
  logic sys_clk, rst_n, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rdat;
  logic [1:0] htrans;
  adcz_result_s result;
  adcz_route_s [3:0] slotRoute;
  logic [15:0] zxModes, slotEnable;
  logic [7:0] crossFlags;
  int badCount, cmpCount, mZx, mSel, mSdis, mCtrl, mFlags;
  int seeded[16], sgn[16];
  adcz_slot_ctrl adcz_slot_ctrl_inst (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .result(result), .zxModes(zxModes), .slotRoute(slotRoute), .slotEnable(slotEnable),
    .crossFlags(crossFlags));
  adcz_seq_model adcz_seq_model_inst (.sys_clk(sys_clk), .result(result));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // ****************************************************************
  // Bus and model tasks.
  // ****************************************************************
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmpCount, badCount);
    if (badCount == 0 && cmpCount > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmpCount++;
    if (got !== exp) begin
      badCount++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdata);
    int n;
    n = 0;
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= addr;
    hwrite <= wr;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wdata;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    rdat = hrdata;
    check({31'h0, hresp}, 32'h0, "bus response not OKAY");
    if (n >= 40) begin
      check(1'b0, 1'b1, "bus answer timed out");
    end
  endtask
  task automatic rd(input logic [31:0] addr, input int exp, input string what);
    xfer(1'b0, addr, 32'h0);
    check(rdat, exp, what);
  endtask
  task automatic wr(input logic [31:0] addr, input logic [31:0] v);
    xfer(1'b1, addr, v);
    case (addr)
      32'h0C: mZx = v[15:0];
      32'h10: mSel = v[15:0];
      32'h18: mSdis = v[15:0];
      32'h1C: mFlags = mFlags & ~v[7:0];
      32'h20: mCtrl = v[0];
      default: ;
    endcase
  endtask
  function automatic logic [15:0] tailEn(input int sdis);
    logic [15:0] e;
    logic stop;
    stop = 1'b0;
    for (int i = 0; i < 16; i++) begin
      stop = stop | sdis[i];
      e[i] = ~stop;
    end
    return e;
  endfunction
  task automatic checkOuts();
    adcz_route_s e;
    logic [3:0] c;
    @(posedge sys_clk);
    #1;
    check(zxModes, mZx, "mode outputs");
    check(slotEnable, tailEn(mSdis), "slot enables");
    check(crossFlags, mFlags, "crossing flags");
    for (int i = 0; i < 4; i++) begin
      c = 4'(mSel >> (4 * i));
      e.diff = mCtrl[0];
      e.posInput = mCtrl[0] ? {c[3:1], 1'b0} : c;
      e.negInput = mCtrl[0] ? {c[3:1], 1'b1} : c;
      check({23'h0, slotRoute[i]}, {23'h0, e}, "slot route");
    end
  endtask
  task automatic readAll();
    rd(32'h0C, mZx, "mode register");
    rd(32'h10, mSel, "selector register");
    rd(32'h18, mSdis, "disable register");
    rd(32'h1C, mFlags, "flag register");
    rd(32'h20, mCtrl, "control register");
    rd(32'h24, 0, "unmapped word");
    rd(32'h10C, 0, "address above map");
  endtask
  // A slot's first result only seeds its sign, so no flag can come from it.
  task automatic sendRes(input int s, input logic [15:0] d, input int gap);
    int m;
    adcz_seq_model_inst.send(s[3:0], d, gap);
    if (s >= 8) begin
      m = (mZx >> (2 * (s - 8))) & 3;
      if (seeded[s] == 1 && sgn[s] != d[15] && (m == 3 || (m == 1 && d[15]) ||
          (m == 2 && !d[15]))) begin
        mFlags = mFlags | (1 << (s - 8));
      end
      seeded[s] = 1;
      sgn[s] = d[15];
    end
  endtask
  // ****************************************************************
  // Test sequence.
  // ****************************************************************
  initial begin
    #400000;
    badCount++;
    $display("[ERR] %0t watchdog expired", $time);
    conclude();
  end
  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    mSel = 32'h3210;
    void'($urandom(15));
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    checkOuts();
    readAll();
    $display("test reset done");
    for (int d = 0; d < 2; d++) begin
      wr(32'h20, d);
      for (int c = 0; c < 4; c++) begin
        wr(32'h10, 32'hFFFF_0000 | (4 * c << 12) | ((4 * c + 1) << 8) | ((4 * c + 2) << 4) | (4 * c + 3));
        checkOuts();
      end
    end
    $display("test input routing done");
    for (int k = 0; k < 8; k++) begin
      wr(32'h0C, $urandom);
      wr(32'h10, $urandom);
      wr(32'h18, k == 0 ? 32'h0 : $urandom << ($urandom % 16));
      wr(32'h24, $urandom);
      checkOuts();
      readAll();
    end
    $display("test registers done");
    for (int r = 0; r < 8; r++) begin
      wr(32'h0C, r < 4 ? r * 32'h5555 : $urandom);
      for (int k = 0; k < 24; k++) begin
        sendRes($urandom_range(15, 4), k % 5 == 0 ? 16'h0 : 16'($urandom), $urandom % 3);
      end
      repeat (2) @(posedge sys_clk);
      checkOuts();
      rd(32'h1C, mFlags, "flag register");
      wr(32'h1C, 32'hFF);
      checkOuts();
    end
    $display("test crossings done");
    conclude();
  end
endmodule
`default_nettype wire
